// [inc/atu_map.svh]
`ifndef ATU_MAP_SVH
`define ATU_MAP_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ATU_OFS_FLAGS 8'h17
`define ATU_OFS_GPC 8'h23
`define ATU_OFS_MASK 8'h70
`define ATU_OFS_CTL_A 8'hb0
`define ATU_OFS_CTL_B 8'hb1
`define ATU_OFS_COUNT 8'hb2
`define ATU_OFS_CMP_A 8'hb3
`define ATU_OFS_CMP_B 8'hb4
`define ATU_OFS_STATUS 8'hb6
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ATU_BIT_OVF 0
`define ATU_BIT_CMPA 1
`define ATU_BIT_CMPB 2
`define ATU_BIT_BUSY_CTL_B 0
`define ATU_BIT_BUSY_CTL_A 1
`define ATU_BIT_BUSY_CMP_B 2
`define ATU_BIT_BUSY_CMP_A 3
`define ATU_BIT_BUSY_COUNT 4
`define ATU_BIT_ASYNC_SEL 5
`define ATU_BIT_EXT_CLK 6
`define ATU_BIT_SYNC_PSR 0
`define ATU_BIT_ASYNC_PSR 1
`define ATU_BIT_SYNC_MODE 7
`define ATU_CTL_B_KEEP 8'h0f
`define ATU_IRQ_KEEP 8'h07
`define ATU_BIT_WGM2 3
// ---------------------------------------------------------------
// Reset values and prescaler taps
// ---------------------------------------------------------------
`define ATU_RST_BYTE 8'h00
`define ATU_RST_PSC 10'h000
`define ATU_BYTE_MAX 8'hff
`define ATU_BYTE_MIN 8'h00
`define ATU_TAP_8 10'h007
`define ATU_TAP_32 10'h01f
`define ATU_TAP_64 10'h03f
`define ATU_TAP_128 10'h07f
`define ATU_TAP_256 10'h0ff
`define ATU_TAP_1024 10'h3ff
`endif

// [inc/atu_pkg.sv]
package atu_pkg;
	// Register and data byte
	typedef logic [7:0] atu_byte_t;
	// Three interrupt sources: overflow, compare A, compare B
	typedef logic [2:0] atu_irq_t;
	// Counting direction, one-hot
	typedef enum logic [1:0] {
		ATU_DIR_UP = 2'b01,
		ATU_DIR_DOWN = 2'b10
	} atu_dir_t;
endpackage

// [logic/atu_prescaler.sv]
`include "atu_map.svh"
`default_nettype none
module atu_prescaler (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic base_tick,
	input wire logic clear,
	input wire logic [2:0] clk_sel,
	// Count enable pulse
	output logic cnt_en
);
	import atu_pkg::*;
	logic [9:0] psc_r;
	logic [9:0] psc_nxt;
	logic [9:0] tap;
	// Tap mask per clock select; zero means every base tick
	function automatic logic [9:0] tap_of(input logic [2:0] sel);
		case (sel)
			3'h2: tap_of = `ATU_TAP_8;
			3'h3: tap_of = `ATU_TAP_32;
			3'h4: tap_of = `ATU_TAP_64;
			3'h5: tap_of = `ATU_TAP_128;
			3'h6: tap_of = `ATU_TAP_256;
			3'h7: tap_of = `ATU_TAP_1024;
			default: tap_of = `ATU_RST_PSC;
		endcase
	endfunction
	assign tap = tap_of(clk_sel);
	assign psc_nxt = clear ? `ATU_RST_PSC : (base_tick ? psc_r + 10'h001 : psc_r);
	// A held clear also halts the timer, not only the divider
	assign cnt_en = base_tick & ~clear & (clk_sel != 3'h0) & ((psc_r & tap) == tap);
	// Free running divider
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			psc_r <= `ATU_RST_PSC;
		else
			psc_r <= psc_nxt;
	end
endmodule
`default_nettype wire

// [logic/atu_counter.sv]
`include "atu_map.svh"
`default_nettype none
module atu_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic cnt_en,
	input wire logic load,
	input wire atu_pkg::atu_byte_t load_val,
	input wire logic [2:0] wgm,
	input wire atu_pkg::atu_byte_t cmp_a,
	input wire atu_pkg::atu_byte_t cmp_b,
	// State and events
	output atu_pkg::atu_byte_t count,
	output logic ovf,
	output logic match_a,
	output logic match_b
);
	import atu_pkg::*;
	atu_byte_t cnt_r;
	atu_byte_t cnt_nxt;
	atu_byte_t top;
	atu_dir_t dir_r;
	atu_dir_t dir_nxt;
	logic phase;
	logic at_top;
	logic at_bot;
	// Mode decode: OCRA as top for CTC and the upper modes
	assign top = (wgm[2] | (wgm == 3'h2)) ? cmp_a : `ATU_BYTE_MAX;
	assign phase = wgm[0] & ~wgm[1];
	assign at_top = (cnt_r == top);
	assign at_bot = (cnt_r == `ATU_BYTE_MIN);
	assign match_a = cnt_en & (cnt_r == cmp_a);
	assign match_b = cnt_en & (cnt_r == cmp_b);
	// Overflow: reversal at bottom in phase correct, else max or top
	assign ovf = cnt_en & (phase ? (dir_r == ATU_DIR_DOWN) & at_bot
		: ((wgm == 3'h7) ? at_top : (cnt_r == `ATU_BYTE_MAX)));
	// Next count and direction
	always_comb
	begin
		cnt_nxt = cnt_r;
		dir_nxt = dir_r;
		if (load)
			cnt_nxt = load_val;
		else if (cnt_en)
		begin
			unique case (dir_r)
				ATU_DIR_UP:
				begin
					if (at_top && phase)
					begin
						dir_nxt = ATU_DIR_DOWN;
						cnt_nxt = cnt_r - 8'h01;
					end
					else if (at_top)
						cnt_nxt = `ATU_BYTE_MIN;
					else
						cnt_nxt = cnt_r + 8'h01;
				end
				ATU_DIR_DOWN:
				begin
					if (at_bot || !phase)
					begin
						dir_nxt = ATU_DIR_UP;
						cnt_nxt = cnt_r + 8'h01;
					end
					else
						cnt_nxt = cnt_r - 8'h01;
				end
			endcase
		end
	end
	// Counter state
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_r <= `ATU_RST_BYTE;
			dir_r <= ATU_DIR_UP;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			dir_r <= dir_nxt;
		end
	end
	assign count = cnt_r;
endmodule
`default_nettype wire

// [logic/atu_top.sv]
// Operation
// - Async write to compare B sets busy bit 2 until transfer to live.
// - Async write to control A sets busy bit 1 until transfer to live.
// - Async write to control B sets busy bit 0 until transfer to live.
// - Async write to counter sets busy bit 4 until counter is loaded.
// - Async write to compare A sets busy bit 3 until transfer to live.
// - Counter reads live value; compares and controls read holding registers.
// - Mask bits 0..2 enable overflow, compare A, compare B with global enable.
// - Compare B match sets flag bit 2; request when flag, enable, global.
// - Compare A match sets flag bit 1; request when flag, enable, global.
// - Overflow sets flag bit 0; phase correct sets it at bottom reversal.
// - Vector execution clears the matching interrupt flag.
// - Writing one clears a flag; writing zero leaves it.
// - Sync mode bit 7 keeps both prescaler reset bits as written.
// - Clearing sync mode clears both prescaler resets; timers restart together.
// - Async prescaler reset bit 1 resets prescaler, self clears unless sync mode.
// - In async mode the bit stays one until the prescaler reset completes.
// - Sync prescaler reset bit 0 resets shared prescaler, self clears unless sync mode.
`include "atu_map.svh"
`default_nettype none
module atu_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire atu_pkg::atu_byte_t addr,
	input wire atu_pkg::atu_byte_t wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output atu_pkg::atu_byte_t rd_data,
	// Asynchronous timer clock, sampled
	input wire logic async_clk_in,
	// Interrupt handshake
	input wire logic global_irq_enable,
	input wire atu_pkg::atu_irq_t irq_ack,
	output atu_pkg::atu_irq_t irq_req,
	// Reset to the prescaler shared by the other timers
	output logic sync_prescaler_reset
);
	import atu_pkg::*;

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	atu_byte_t rd_data_r;
	atu_byte_t rd_nxt;
	atu_irq_t irq_req_r;
	atu_irq_t irq_req_nxt;
	logic sync_psr_out_r;
	logic async_clk_prev_r;
	logic timer_tick;
	logic base_tick;
	atu_byte_t ctl_a_r;
	atu_byte_t ctl_b_r;
	atu_byte_t cmp_a_r;
	atu_byte_t cmp_b_r;
	atu_byte_t hold_ctl_a_r;
	atu_byte_t hold_ctl_b_r;
	atu_byte_t hold_cmp_a_r;
	atu_byte_t hold_cmp_b_r;
	atu_byte_t hold_cnt_r;
	logic [4:0] busy_r;
	logic [4:0] busy_nxt;
	logic [4:0] wr_hit;
	logic async_mode_r;
	logic ext_clk_r;
	atu_byte_t mask_r;
	atu_byte_t mask_nxt;
	atu_irq_t flags_r;
	atu_irq_t flags_nxt;
	atu_irq_t flag_set;
	atu_irq_t flag_clr;
	logic sync_mode_r;
	logic sync_psr_r;
	logic sync_psr_nxt;
	logic async_psr_r;
	logic async_psr_nxt;
	logic async_psr_done;
	logic we_flags;
	logic we_gpc;
	logic we_mask;
	logic we_status;
	logic cnt_load;
	atu_byte_t cnt_load_val;
	logic cnt_en;
	atu_byte_t count;
	logic ev_ovf;
	logic ev_match_a;
	logic ev_match_b;
	atu_byte_t status_view;
	atu_byte_t gpc_view;

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	// One write enable per register; the busy group indexed by busy bit
	function automatic logic hit(input atu_byte_t a, input atu_byte_t ofs);
		hit = (a == ofs);
	endfunction
	assign we_flags = wr_en & hit(addr, `ATU_OFS_FLAGS);
	assign we_gpc = wr_en & hit(addr, `ATU_OFS_GPC);
	assign we_mask = wr_en & hit(addr, `ATU_OFS_MASK);
	assign we_status = wr_en & hit(addr, `ATU_OFS_STATUS);
	assign wr_hit[`ATU_BIT_BUSY_CTL_B] = wr_en & hit(addr, `ATU_OFS_CTL_B);
	assign wr_hit[`ATU_BIT_BUSY_CTL_A] = wr_en & hit(addr, `ATU_OFS_CTL_A);
	assign wr_hit[`ATU_BIT_BUSY_CMP_B] = wr_en & hit(addr, `ATU_OFS_CMP_B);
	assign wr_hit[`ATU_BIT_BUSY_CMP_A] = wr_en & hit(addr, `ATU_OFS_CMP_A);
	assign wr_hit[`ATU_BIT_BUSY_COUNT] = wr_en & hit(addr, `ATU_OFS_COUNT);

	// ---------------------------------------------------------------
	// Timer clock
	// ---------------------------------------------------------------
	// Rising edge of the sampled timer clock; in sync mode every cycle counts
	assign timer_tick = async_clk_in & ~async_clk_prev_r;
	assign base_tick = async_mode_r ? timer_tick : 1'b1;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			async_clk_prev_r <= 1'b0;
		else
			async_clk_prev_r <= async_clk_in;
	end

	// ---------------------------------------------------------------
	// Update busy flags
	// ---------------------------------------------------------------
	// A pending value moves to live only on a timer clock edge, and the busy
	// bit drops on that same edge, so software never sees idle before live.
	// A write that lands on the transfer edge keeps the bit set.
	assign busy_nxt = async_mode_r ? ((busy_r & {5{~timer_tick}}) | wr_hit) : 5'h00;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			busy_r <= 5'h00;
		else
			busy_r <= busy_nxt;
	end

	// ---------------------------------------------------------------
	// Holding registers
	// ---------------------------------------------------------------
	// Every write lands here, in sync mode in the same cycle as live; overwriting while busy is not guarded
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hold_ctl_a_r <= `ATU_RST_BYTE;
			hold_ctl_b_r <= `ATU_RST_BYTE;
			hold_cmp_a_r <= `ATU_RST_BYTE;
			hold_cmp_b_r <= `ATU_RST_BYTE;
			hold_cnt_r <= `ATU_RST_BYTE;
		end
		else
		begin
			if (wr_hit[`ATU_BIT_BUSY_CTL_A])
				hold_ctl_a_r <= wr_data;
			if (wr_hit[`ATU_BIT_BUSY_CTL_B])
				hold_ctl_b_r <= wr_data & `ATU_CTL_B_KEEP; // Force strobes read as zero
			if (wr_hit[`ATU_BIT_BUSY_CMP_A])
				hold_cmp_a_r <= wr_data;
			if (wr_hit[`ATU_BIT_BUSY_CMP_B])
				hold_cmp_b_r <= wr_data;
			if (wr_hit[`ATU_BIT_BUSY_COUNT])
				hold_cnt_r <= wr_data;
		end
	end

	// ---------------------------------------------------------------
	// Live registers
	// ---------------------------------------------------------------
	// Sync mode: written straight through. Async mode: copied on the timer edge.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctl_a_r <= `ATU_RST_BYTE;
			ctl_b_r <= `ATU_RST_BYTE;
			cmp_a_r <= `ATU_RST_BYTE;
			cmp_b_r <= `ATU_RST_BYTE;
		end
		else if (!async_mode_r)
		begin
			if (wr_hit[`ATU_BIT_BUSY_CTL_A])
				ctl_a_r <= wr_data;
			if (wr_hit[`ATU_BIT_BUSY_CTL_B])
				ctl_b_r <= wr_data & `ATU_CTL_B_KEEP;
			if (wr_hit[`ATU_BIT_BUSY_CMP_A])
				cmp_a_r <= wr_data;
			if (wr_hit[`ATU_BIT_BUSY_CMP_B])
				cmp_b_r <= wr_data;
		end
		else if (timer_tick)
		begin
			if (busy_r[`ATU_BIT_BUSY_CTL_A])
				ctl_a_r <= hold_ctl_a_r;
			if (busy_r[`ATU_BIT_BUSY_CTL_B])
				ctl_b_r <= hold_ctl_b_r;
			if (busy_r[`ATU_BIT_BUSY_CMP_A])
				cmp_a_r <= hold_cmp_a_r;
			if (busy_r[`ATU_BIT_BUSY_CMP_B])
				cmp_b_r <= hold_cmp_b_r;
		end
	end

	// Counter load: immediate in sync mode, on the timer edge in async mode
	assign cnt_load = async_mode_r ? (timer_tick & busy_r[`ATU_BIT_BUSY_COUNT])
		: wr_hit[`ATU_BIT_BUSY_COUNT];
	assign cnt_load_val = async_mode_r ? hold_cnt_r : wr_data;

	// ---------------------------------------------------------------
	// Mode and mask registers
	// ---------------------------------------------------------------
	// Leaving async mode clears the busy bits, so pending transfers never reach live
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			async_mode_r <= 1'b0;
			ext_clk_r <= 1'b0;
			mask_r <= `ATU_RST_BYTE;
		end
		else
		begin
			if (we_status)
			begin
				async_mode_r <= wr_data[`ATU_BIT_ASYNC_SEL];
				ext_clk_r <= wr_data[`ATU_BIT_EXT_CLK];
			end
			mask_r <= mask_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Prescaler reset control
	// ---------------------------------------------------------------
	// Async reset completes on the next timer edge; in sync mode at once
	assign async_psr_done = ~async_mode_r | timer_tick;
	// A write stores the written bits; without sync mode hardware clears them
	assign async_psr_nxt = we_gpc ? wr_data[`ATU_BIT_ASYNC_PSR]
		: (async_psr_r & (sync_mode_r | ~async_psr_done));
	assign sync_psr_nxt = we_gpc ? wr_data[`ATU_BIT_SYNC_PSR]
		: (sync_psr_r & sync_mode_r);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sync_mode_r <= 1'b0;
			async_psr_r <= 1'b0;
			sync_psr_r <= 1'b0;
		end
		else
		begin
			if (we_gpc)
				sync_mode_r <= wr_data[`ATU_BIT_SYNC_MODE];
			async_psr_r <= async_psr_nxt;
			sync_psr_r <= sync_psr_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Timer core
	// ---------------------------------------------------------------
	atu_prescaler u_psc (
		.clk(clk),
		.rst(rst),
		.base_tick(base_tick),
		.clear(async_psr_r),
		.clk_sel(ctl_b_r[2:0]),
		.cnt_en(cnt_en)
	);

	atu_counter u_cnt (
		.clk(clk),
		.rst(rst),
		.cnt_en(cnt_en),
		.load(cnt_load),
		.load_val(cnt_load_val),
		.wgm({ctl_b_r[`ATU_BIT_WGM2], ctl_a_r[1:0]}),
		.cmp_a(cmp_a_r),
		.cmp_b(cmp_b_r),
		.count(count),
		.ovf(ev_ovf),
		.match_a(ev_match_a),
		.match_b(ev_match_b)
	);

	// ---------------------------------------------------------------
	// Interrupt flags
	// ---------------------------------------------------------------
	// A new event wins over a clear in the same cycle, so no event is lost
	assign flag_set[`ATU_BIT_OVF] = ev_ovf;
	assign flag_set[`ATU_BIT_CMPA] = ev_match_a;
	assign flag_set[`ATU_BIT_CMPB] = ev_match_b;
	assign flag_clr = irq_ack | (wr_data[2:0] & {3{we_flags}});
	assign flags_nxt = (flags_r & ~flag_clr) | flag_set;
	assign mask_nxt = we_mask ? (wr_data & `ATU_IRQ_KEEP) : mask_r;
	assign irq_req_nxt = flags_nxt & mask_nxt[2:0] & {3{global_irq_enable}};

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			flags_r <= 3'h0;
			irq_req_r <= 3'h0;
		end
		else
		begin
			flags_r <= flags_nxt;
			irq_req_r <= irq_req_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	// Counter reads live; compares and controls show the holding copy
	assign status_view = {1'b0, ext_clk_r, async_mode_r, busy_r};
	assign gpc_view = {sync_mode_r, 5'h00, async_psr_r, sync_psr_r};

	always_comb
	begin
		rd_nxt = `ATU_RST_BYTE;
		if (rd_en)
		begin
			case (addr)
				`ATU_OFS_FLAGS: rd_nxt = {5'h00, flags_r};
				`ATU_OFS_GPC: rd_nxt = gpc_view;
				`ATU_OFS_MASK: rd_nxt = mask_r;
				`ATU_OFS_STATUS: rd_nxt = status_view;
				`ATU_OFS_COUNT: rd_nxt = count;
				`ATU_OFS_CTL_A: rd_nxt = hold_ctl_a_r;
				`ATU_OFS_CTL_B: rd_nxt = hold_ctl_b_r;
				`ATU_OFS_CMP_A: rd_nxt = hold_cmp_a_r;
				`ATU_OFS_CMP_B: rd_nxt = hold_cmp_b_r;
				default: rd_nxt = `ATU_RST_BYTE;
			endcase
		end
	end

	// Read data and the outgoing prescaler reset, all registered
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rd_data_r <= `ATU_RST_BYTE;
			sync_psr_out_r <= 1'b0;
		end
		else
		begin
			rd_data_r <= rd_nxt;
			sync_psr_out_r <= sync_psr_nxt;
		end
	end

	assign rd_data = rd_data_r;
	assign irq_req = irq_req_r;
	assign sync_prescaler_reset = sync_psr_out_r;
endmodule
`default_nettype wire

// [bench/atu_checker.sv]
`include "atu_map.svh"
`default_nettype none
module atu_checker
	import atu_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire atu_pkg::atu_byte_t addr,
	input wire atu_pkg::atu_byte_t wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire atu_pkg::atu_byte_t rd_data,
	// Timer clock and interrupts
	input wire logic async_clk_in,
	input wire logic global_irq_enable,
	input wire atu_pkg::atu_irq_t irq_ack,
	input wire atu_pkg::atu_irq_t irq_req,
	input wire logic sync_prescaler_reset
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// ---------------------------------------------
	// Shadow of the mask and write decodes
	// ---------------------------------------------
	wire logic gpc_wr;
	wire logic clr_wr;
	atu_irq_t mask_sh;
	assign gpc_wr = wr_en && (addr == `ATU_OFS_GPC);
	assign clr_wr = wr_en && (addr == `ATU_OFS_FLAGS || addr == `ATU_OFS_MASK);
	// Either the old or the new mask may gate a request in the write cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			mask_sh <= 3'b000;
		else if (wr_en && addr == `ATU_OFS_MASK)
			mask_sh <= wr_data[2:0];
	end

	// ---------------------------------------------
	// Properties
	// ---------------------------------------------
	rd_idle_a: assert property (!rd_en |=> rd_data == 8'h00)
		else $error("read data not zero outside a read");
	unmapped_rd_a: assert property (rd_en && addr == 8'h00 |=> rd_data == 8'h00)
		else $error("unmapped read not zero");
	ctl_b_resv_a: assert property (rd_en && addr == `ATU_OFS_CTL_B |=> rd_data[7:4] == 4'h0)
		else $error("control B upper bits not zero");
	flag_resv_a: assert property (rd_en && addr == `ATU_OFS_FLAGS |=> rd_data[7:3] == 5'h00)
		else $error("flag register upper bits not zero");
	irq_global_a: assert property (!global_irq_enable |=> irq_req == 3'b000)
		else $error("request without global enable");
	irq_mask_a: assert property ((irq_req & ~(mask_sh | $past(mask_sh))) == 3'b000)
		else $error("request without its enable");
	irq_hold_a: assert property (global_irq_enable && !clr_wr |=>
		(irq_req & $past(irq_req & ~irq_ack)) == $past(irq_req & ~irq_ack))
		else $error("request dropped without a clear");
	psr_follow_a: assert property (gpc_wr |=> sync_prescaler_reset == $past(wr_data[0]))
		else $error("shared prescaler reset not as written");
	psr_selfclr_a: assert property (gpc_wr && wr_data[0] && !wr_data[7] ##1 !gpc_wr |=> !sync_prescaler_reset)
		else $error("shared prescaler reset not self clearing");
	psr_hold_a: assert property (gpc_wr && wr_data[7] && wr_data[0] ##1 (!gpc_wr)[*3] |=> sync_prescaler_reset)
		else $error("shared prescaler reset not held");
endmodule

bind atu_top atu_checker atu_checker_i (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
	.rd_en(rd_en), .rd_data(rd_data), .async_clk_in(async_clk_in), .global_irq_enable(global_irq_enable),
	.irq_ack(irq_ack), .irq_req(irq_req), .sync_prescaler_reset(sync_prescaler_reset));
`default_nettype wire

// [bench/atu_top_bench.sv]
`include "atu_map.svh"
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			err_count++; \
			$display("ERROR %s expected %h seen %h", nm, e, g); \
		end \
	end
module atu_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import atu_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	atu_byte_t addr = 8'h00;
	atu_byte_t wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	atu_byte_t rd_data;
	logic async_clk_in = 1'b0;
	logic global_irq_enable = 1'b0;
	atu_irq_t irq_ack = 3'b000;
	atu_irq_t irq_req;
	logic sync_prescaler_reset;
	int err_count = 0;
	int total_checks = 0;

	atu_top atu_top_i (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data(rd_data), .async_clk_in(async_clk_in), .global_irq_enable(global_irq_enable),
		.irq_ack(irq_ack), .irq_req(irq_req), .sync_prescaler_reset(sync_prescaler_reset));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	// ---------------------------------------------
	// Bus cycles
	// ---------------------------------------------
	task automatic wr(input atu_byte_t a, input atu_byte_t d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input atu_byte_t a, input atu_byte_t e, input string nm);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		`CHK(nm, e, rd_data)
	endtask

	// One rising edge of the timer clock, long enough to be sampled
	task automatic tick();
		@(posedge clk);
		async_clk_in <= 1'b1;
		repeat (4) @(posedge clk);
		async_clk_in <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task automatic finish_test();
		$display("Checks %0d, errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ---------------------------------------------
	// Scenarios
	// ---------------------------------------------
	// Reset values; unmapped address ignores writes
	task automatic t_reset();
		rd_chk(`ATU_OFS_FLAGS, 8'h00, "flags");
		rd_chk(`ATU_OFS_GPC, 8'h00, "gpc");
		rd_chk(`ATU_OFS_MASK, 8'h00, "mask");
		rd_chk(`ATU_OFS_STATUS, 8'h00, "status");
		wr(8'h00, 8'hff);
		rd_chk(8'h00, 8'h00, "unmapped");
	endtask

	// Busy bits pile up while the timer clock stands still
	task automatic t_async();
		atu_byte_t ofs [5] = '{`ATU_OFS_COUNT, `ATU_OFS_CMP_A, `ATU_OFS_CMP_B, `ATU_OFS_CTL_A, `ATU_OFS_CTL_B};
		atu_byte_t val [5] = '{8'h5a, 8'h11, 8'h22, 8'h40, 8'h08};
		atu_byte_t exp;
		exp = 8'h20;
		wr(`ATU_OFS_STATUS, 8'h20);
		for (int i = 0; i < 5; i++)
		begin
			wr(ofs[i], val[i]);
			exp[4 - i] = 1'b1;
			rd_chk(`ATU_OFS_STATUS, exp, "busy set");
		end
		rd_chk(`ATU_OFS_COUNT, 8'h00, "live count");
		for (int i = 1; i < 5; i++)
			rd_chk(ofs[i], val[i], "holding");
		tick();
		// Rewrites wait for busy to drop, else the value may be lost
		rd_chk(`ATU_OFS_STATUS, 8'h20, "busy clear");
		rd_chk(`ATU_OFS_COUNT, 8'h5a, "count loaded");
		wr(`ATU_OFS_GPC, 8'h02);
		repeat (2) @(posedge clk);
		rd_chk(`ATU_OFS_GPC, 8'h02, "psr pending");
		tick();
		rd_chk(`ATU_OFS_GPC, 8'h00, "psr done");
		wr(`ATU_OFS_STATUS, 8'h00);
	endtask

	// Normal mode run past both compares and the top
	task automatic t_irq();
		wr(`ATU_OFS_CTL_A, 8'h00);
		wr(`ATU_OFS_CMP_A, 8'h03);
		wr(`ATU_OFS_CMP_B, 8'h05);
		wr(`ATU_OFS_COUNT, 8'h00);
		wr(`ATU_OFS_MASK, 8'h07);
		rd_chk(`ATU_OFS_MASK, 8'h07, "mask");
		wr(`ATU_OFS_CTL_B, 8'h01);
		repeat (300) @(posedge clk);
		wr(`ATU_OFS_CTL_B, 8'h00);
		rd_chk(`ATU_OFS_FLAGS, 8'h07, "flags set");
		`CHK("irq no global", 3'b000, irq_req)
		@(posedge clk);
		global_irq_enable <= 1'b1;
		@(posedge clk);
		#1;
		`CHK("irq all", 3'b111, irq_req)
		wr(`ATU_OFS_FLAGS, 8'h02);
		rd_chk(`ATU_OFS_FLAGS, 8'h05, "w1c");
		`CHK("irq after w1c", 3'b101, irq_req)
		@(posedge clk);
		irq_ack <= 3'b100;
		@(posedge clk);
		irq_ack <= 3'b000;
		rd_chk(`ATU_OFS_FLAGS, 8'h01, "ack");
		wr(`ATU_OFS_MASK, 8'h06);
		@(posedge clk);
		#1;
		`CHK("irq masked", 3'b000, irq_req)
		wr(`ATU_OFS_FLAGS, 8'h01);
		rd_chk(`ATU_OFS_FLAGS, 8'h00, "w1c last");
		@(posedge clk);
		global_irq_enable <= 1'b0;
	endtask

	// Phase correct: no overflow at the top, only at the bottom reversal
	task automatic t_pwm();
		wr(`ATU_OFS_CTL_A, 8'h01);
		wr(`ATU_OFS_COUNT, 8'h10);
		wr(`ATU_OFS_CTL_B, 8'h01);
		repeat (400) @(posedge clk);
		wr(`ATU_OFS_CTL_B, 8'h00);
		rd_chk(`ATU_OFS_FLAGS, 8'h00, "no flag at top");
		wr(`ATU_OFS_CTL_B, 8'h01);
		repeat (200) @(posedge clk);
		wr(`ATU_OFS_CTL_B, 8'h00);
		rd_chk(`ATU_OFS_FLAGS, 8'h07, "flag at bottom");
		wr(`ATU_OFS_FLAGS, 8'h07);
		wr(`ATU_OFS_CTL_A, 8'h00);
	endtask

	// Prescaler resets with and without the hold mode
	task automatic t_psr();
		wr(`ATU_OFS_GPC, 8'h01);
		#1;
		`CHK("sync psr on", 1'b1, sync_prescaler_reset)
		rd_chk(`ATU_OFS_GPC, 8'h00, "sync psr clr");
		`CHK("sync psr off", 1'b0, sync_prescaler_reset)
		wr(`ATU_OFS_GPC, 8'h02);
		@(posedge clk);
		rd_chk(`ATU_OFS_GPC, 8'h00, "async psr clr");
		wr(`ATU_OFS_GPC, 8'h83);
		wr(`ATU_OFS_COUNT, 8'h20);
		wr(`ATU_OFS_CTL_B, 8'h01);
		repeat (20) @(posedge clk);
		rd_chk(`ATU_OFS_COUNT, 8'h20, "halted");
		rd_chk(`ATU_OFS_GPC, 8'h83, "hold");
		`CHK("sync psr held", 1'b1, sync_prescaler_reset)
		wr(`ATU_OFS_GPC, 8'h03);
		@(posedge clk);
		rd_chk(`ATU_OFS_GPC, 8'h00, "release");
		`CHK("release out", 1'b0, sync_prescaler_reset)
		wr(`ATU_OFS_CTL_B, 8'h00);
		// Four counting edges between the release and the stop
		rd_chk(`ATU_OFS_COUNT, 8'h24, "resumed");
	endtask

	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_async();
		t_irq();
		t_pwm();
		t_psr();
		finish_test();
	end

	// Watchdog: the sequence needs under 3000 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		finish_test();
	end
endmodule
`default_nettype wire
